// ===== cpc_top.sv
`timescale 1ns/1ps
`include "cpc_defs.svh"
module cpc_top
#(
   parameter int unsigned WD_CYCLES = `CPC_WD_PERIOD_MS * 1000 * `CPC_CLK_MHZ
)
(
   // clock and reset
   input  wire logic                  clk,
   input  wire logic                  rst_n,
   // register port
   input  wire logic                  reg_wr,
   input  wire logic                  reg_rd,
   input  wire logic [7:0]            reg_addr,
   input  wire logic [7:0]            reg_wdata,
   output      logic [7:0]            reg_rdata,
   // setting sources
   input  wire cpc_pkg::cpc_settings_t resistor_settings,
   input  wire cpc_pkg::cpc_settings_t host_settings,
   input  wire logic                  resistor_fault,
   input  wire logic                  battery_switch_disable_pin,
   // power-path state machine requests
   input  wire logic                  ppsm_batt_switch_on,
   input  wire logic                  ppsm_dcdc_on,
   // effects
   output      cpc_pkg::cpc_settings_t active_settings,
   output      logic                  charger_suspended,
   output      logic                  batt_switch_on,
   output      logic                  dcdc_on,
   output      logic                  input_standby,
   output      logic                  charger_enable,
   output      cpc_pkg::cpc_path_t    path_config,
   output      logic                  watchdog_expired
);
   // ==========================================
   // decode
   function automatic cpc_pkg::cpc_path_t mode_decode(input logic [3:0] code);
      if (code <= 4'h3)
         mode_decode = cpc_pkg::CPC_ALL_OFF;
      else if (code == 4'h4)
         mode_decode = cpc_pkg::CPC_DCDC;
      else if (code <= 4'h7)
         mode_decode = cpc_pkg::CPC_CHARGE;
      else if (code == 4'hA)
         mode_decode = cpc_pkg::CPC_REVERSE;
      else
         mode_decode = cpc_pkg::CPC_ALL_OFF;
   endfunction

   logic                   host_programming_select;
   logic                   battery_path_force_off;
   logic                   input_standby_force;
   logic                   host_watchdog_enable;
   logic [3:0]             mode_code;
   logic [31:0]            wd_count;
   logic                   wd_flag;
   logic                   next_sel;
   logic                   next_bfo;
   logic                   next_stby;
   logic                   next_wden;
   logic [3:0]             next_mode;
   logic [31:0]            next_wd_count;
   logic                   next_wd_flag;
   logic                   next_susp;
   logic [7:0]             next_rdata;
   logic                   cfg_wr;
   logic                   wdclr_wr;
   logic                   bfo_eff;
   cpc_pkg::cpc_path_t     path_eff;
   logic [3:0]             mode_eff;
   logic                   wd_expire;
   cpc_pkg::cpc_settings_t next_active;
   logic                   next_batt_on;
   logic                   next_dcdc_on;
   logic                   next_stby_out;
   logic                   next_chg_en;
   cpc_pkg::cpc_path_t     next_path;
   logic                   next_wd_exp;

   // ==========================================
   // register state
   always_comb
   begin
      cfg_wr    = reg_wr && (reg_addr == `CPC_CFG_OFFSET);
      wdclr_wr  = reg_wr && (reg_addr == `CPC_WDCLR_OFFSET)
                  && (reg_wdata == `CPC_WDCLR_VALUE);                // [RULE10]
      next_sel  = host_programming_select;
      next_bfo  = battery_path_force_off;
      next_stby = input_standby_force;
      next_wden = host_watchdog_enable;
      next_mode = mode_code;
      if (cfg_wr)
      begin
         // a zero write leaves the select alone; only reset clears it
         next_sel  = host_programming_select | reg_wdata[`CPC_SEL_BIT]; // [RULE2] [RULE3]
         next_bfo  = reg_wdata[`CPC_BFO_BIT];
         next_stby = reg_wdata[`CPC_STBY_BIT];
         next_wden = reg_wdata[`CPC_WDEN_BIT];
         next_mode = reg_wdata[3:0];
      end
      next_susp = charger_suspended;
      if (resistor_fault && !host_programming_select)
         next_susp = 1'b1;
      if (cfg_wr && reg_wdata[`CPC_SEL_BIT])
         next_susp = 1'b0;                                           // [RULE4]
   end

   // ==========================================
   // watchdog
   always_comb
   begin
      // a restart in the terminal cycle still counts as in time
      wd_expire     = host_watchdog_enable && !wdclr_wr
                      && (wd_count >= WD_CYCLES - 1);
      next_wd_count = 32'h0;
      next_wd_flag  = wd_flag;
      if (host_watchdog_enable && !wdclr_wr)                         // [RULE9]
      begin
         if (wd_expire)
         begin
            next_wd_flag  = 1'b1;                                    // [RULE13]
            next_wd_count = 32'h0;
         end
         else
            next_wd_count = wd_count + 32'h1;
      end
      // restart or disabling write clears the flag; expiry in the same cycle as a disabling write wins
      if ((wdclr_wr || (cfg_wr && !reg_wdata[`CPC_WDEN_BIT])) && !wd_expire)
         next_wd_flag = 1'b0;
   end

   // ==========================================
   // effective state and read data
   always_comb
   begin
      bfo_eff  = battery_path_force_off | battery_switch_disable_pin;
      path_eff = mode_decode(mode_code);                             // [RULE11]
      if (wd_flag)
         path_eff = cpc_pkg::CPC_DCDC;                               // [RULE13]
      if (input_standby_force && path_eff != cpc_pkg::CPC_REVERSE)
         path_eff = cpc_pkg::CPC_ALL_OFF;                            // [RULE7]
      unique case (path_eff)
         cpc_pkg::CPC_ALL_OFF: mode_eff = 4'h0;
         cpc_pkg::CPC_DCDC:    mode_eff = 4'h4;
         cpc_pkg::CPC_CHARGE:  mode_eff = (mode_code inside {4'h5, 4'h6, 4'h7}) ? mode_code : 4'h5;
         cpc_pkg::CPC_REVERSE: mode_eff = 4'hA;
      endcase
      next_rdata = 8'h00;
      if (reg_rd && reg_addr == `CPC_CFG_OFFSET)
         next_rdata = {host_programming_select, bfo_eff,              // [RULE6]
                       input_standby_force, host_watchdog_enable,     // [RULE8]
                       mode_eff};                                     // [RULE12]
      // outputs lag the state by one cycle
      next_active   = host_programming_select ? host_settings
                                              : resistor_settings;   // [RULE1] [RULE3]
      next_batt_on  = ppsm_batt_switch_on && !bfo_eff;               // [RULE5]
      next_dcdc_on  = ppsm_dcdc_on && (path_eff != cpc_pkg::CPC_ALL_OFF); // [RULE7]
      next_stby_out = input_standby_force;                           // [RULE7]
      next_chg_en   = (path_eff == cpc_pkg::CPC_CHARGE) && !charger_suspended; // [RULE4]
      next_path     = path_eff;
      next_wd_exp   = wd_flag;
   end

   // ==========================================
   // configuration flops
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         host_programming_select <= 1'b0;
         battery_path_force_off  <= 1'b0;
         input_standby_force     <= 1'b0;
         host_watchdog_enable    <= 1'b0;
         mode_code               <= `CPC_MODE_RESET;
         charger_suspended       <= 1'b0;
      end
      else
      begin
         host_programming_select <= next_sel;
         battery_path_force_off  <= next_bfo;
         input_standby_force     <= next_stby;
         host_watchdog_enable    <= next_wden;
         mode_code               <= next_mode;
         charger_suspended       <= next_susp;
      end
   end

   // ==========================================
   // watchdog flops
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         wd_count                <= 32'h0;
         wd_flag                 <= 1'b0;
      end
      else
      begin
         wd_count                <= next_wd_count;
         wd_flag                 <= next_wd_flag;
      end
   end

   // ==========================================
   // output flops; no output is driven by logic directly
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         reg_rdata               <= 8'h00;
         active_settings         <= '0;
         batt_switch_on          <= 1'b0;
         dcdc_on                 <= 1'b0;
         input_standby           <= 1'b0;
         charger_enable          <= 1'b0;
         path_config             <= cpc_pkg::CPC_ALL_OFF;
         watchdog_expired        <= 1'b0;
      end
      else
      begin
         reg_rdata               <= next_rdata;
         active_settings         <= next_active;
         batt_switch_on          <= next_batt_on;
         dcdc_on                 <= next_dcdc_on;
         input_standby           <= next_stby_out;
         charger_enable          <= next_chg_en;
         path_config             <= next_path;
         watchdog_expired        <= next_wd_exp;
      end
   end
endmodule

// ===== cpc_defs.svh
// What this block does
// [RULE1] select 0: settings taken from resistor pins
// [RULE2] writing 0 to select is ignored
// [RULE3] writing 1 selects host-written settings
// [RULE4] writing 1 clears resistor-fault suspension
// [RULE5] force-off bit turns battery switch off
// [RULE6] force-off reads back command or pin
// [RULE7] standby bit forces converter off except in reverse mode, low current in every mode
// [RULE8] standby bit reads back effective setting
// [RULE9] watchdog runs only while enabled
// [RULE10] host restarts watchdog by writing 0x01
// [RULE11] mode code decodes to power-path configuration
// [RULE12] mode reads back effective configuration
// [RULE13] watchdog expiry flags event, leaves normal operation
`ifndef CPC_DEFS_SVH
`define CPC_DEFS_SVH
// ==========================================
// register map
`define CPC_CFG_OFFSET     8'h16
`define CPC_WDCLR_OFFSET   8'h1A
`define CPC_WDCLR_VALUE    8'h01
// ==========================================
// field positions and reset values
`define CPC_SEL_BIT        7
`define CPC_BFO_BIT        6
`define CPC_STBY_BIT       5
`define CPC_WDEN_BIT       4
`define CPC_MODE_RESET     4'h5
// ==========================================
// timing
`define CPC_CLK_MHZ        250
`define CPC_WD_PERIOD_MS   80
`endif

// ===== cpc_pkg.sv
package cpc_pkg;
   typedef enum logic [1:0]
   {
      CPC_ALL_OFF = 2'h0,
      CPC_DCDC    = 2'h1,
      CPC_CHARGE  = 2'h3,
      CPC_REVERSE = 2'h2
   } cpc_path_t;

   typedef struct packed
   {
      logic [7:0] ilim;
      logic [7:0] icc;
      logic [7:0] vcv;
      logic [7:0] topoff_resistor_pin;
   } cpc_settings_t;
endpackage

// ===== cpc_top_chk.sv
`timescale 1ns/1ps
module cpc_top_chk
(
   // watched ports
   input wire logic               clk,
   input wire logic               rst_n,
   input wire logic               reg_wr,
   input wire logic               reg_rd,
   input wire logic [7:0]         reg_addr,
   input wire logic [7:0]         reg_wdata,
   input wire logic [7:0]         reg_rdata,
   input wire logic               battery_switch_disable_pin,
   input wire logic               ppsm_batt_switch_on,
   input wire logic               charger_suspended,
   input wire logic               batt_switch_on,
   input wire logic               input_standby,
   input wire logic               charger_enable,
   input wire cpc_pkg::cpc_path_t path_config,
   input wire logic               watchdog_expired
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // ======
   // port relations
   AST_BATT_REQ: assert property (batt_switch_on |-> $past(ppsm_batt_switch_on))
      else $error("battery switch on without request");
   AST_BATT_PIN: assert property ($past(battery_switch_disable_pin) |-> !batt_switch_on)
      else $error("battery switch on while pin disables it");
   AST_RD_PIN: assert property (reg_rd && reg_addr == 8'h16 && battery_switch_disable_pin |=> reg_rdata[6])
      else $error("force-off readback misses pin");
   AST_SUSP_CLR: assert property (reg_wr && reg_addr == 8'h16 && reg_wdata[7] |-> ##[1:2] !charger_suspended)
      else $error("suspension not cleared");
   AST_SUSP_OFF: assert property (charger_suspended && $past(charger_suspended) |-> !charger_enable)
      else $error("charging while suspended");
   AST_STBY: assert property (input_standby && $past(input_standby) |-> !charger_enable)
      else $error("charging in standby");
   AST_CHG_PATH: assert property (charger_enable |-> path_config == cpc_pkg::CPC_CHARGE)
      else $error("charging outside charge path");
   AST_WD_EXP: assert property (watchdog_expired && $past(watchdog_expired) |-> !charger_enable)
      else $error("charging after watchdog expiry");
endmodule
bind cpc_top cpc_top_chk i_cpc_top_chk (.clk, .rst_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
   .reg_rdata, .battery_switch_disable_pin, .ppsm_batt_switch_on, .charger_suspended,
   .batt_switch_on, .input_standby, .charger_enable, .path_config, .watchdog_expired);

// ===== cpc_ctrl_model.sv
`timescale 1ns/1ps
module cpc_ctrl_model
(
   // register port
   input  wire logic       clk,
   output      logic       reg_wr = 1'b0,
   output      logic       reg_rd = 1'b0,
   output      logic [7:0] reg_addr = 8'h00,
   output      logic [7:0] reg_wdata = 8'h00
);
   // ======
   // one access, held across one sampling edge; released address and data lines show inverted values
   task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      reg_wr = wr;
      reg_rd = !wr;
      reg_addr = a;
      reg_wdata = d;
      @(negedge clk);
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~d;
   endtask
   task automatic kick();
      access(1'b1, 8'h1A, 8'h01);
   endtask
endmodule

// ===== charger_primary_config_register_test.sv
`timescale 1ns/1ps
module charger_primary_config_register_test;
   logic                   clk = 1'b0;
   logic                   rst_n = 1'b0;
   logic                   reg_wr, reg_rd, rd_seen;
   logic [7:0]             reg_addr, reg_wdata, reg_rdata;
   cpc_pkg::cpc_settings_t resistor_settings, host_settings, active_settings;
   logic                   resistor_fault = 1'b0;
   logic                   battery_switch_disable_pin = 1'b0;
   logic                   ppsm_batt_switch_on = 1'b1;
   logic                   ppsm_dcdc_on = 1'b1;
   logic                   charger_suspended, batt_switch_on, dcdc_on;
   logic                   input_standby, charger_enable, watchdog_expired;
   cpc_pkg::cpc_path_t     path_config;
   logic [7:0]             exp_q[$];
   int                     mismatches = 0;
   int                     total_checks = 0;
   cpc_ctrl_model i_cpc_ctrl_model (.clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata);
   cpc_top #(.WD_CYCLES(20)) i_cpc_top (.clk, .rst_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
      .reg_rdata, .resistor_settings, .host_settings, .resistor_fault,
      .battery_switch_disable_pin, .ppsm_batt_switch_on, .ppsm_dcdc_on, .active_settings,
      .charger_suspended, .batt_switch_on, .dcdc_on, .input_standby, .charger_enable,
      .path_config, .watchdog_expired);
   always #2 clk = ~clk;
   // ======
   // checking
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic stop_test();
      $display("checks=%0d mismatches=%0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic rd(input logic [7:0] exp, input logic [7:0] a = 8'h16);
      exp_q.push_back(exp);
      i_cpc_ctrl_model.access(1'b0, a, 8'h00);
   endtask
   task automatic wr(input logic [7:0] d);
      i_cpc_ctrl_model.access(1'b1, 8'h16, d);
      repeat (3) @(negedge clk);
   endtask
   // read data stands only in the cycle after the strobe
   always @(posedge clk) rd_seen <= reg_rd;
   always @(negedge clk)
      if (rd_seen)
         chk(reg_rdata, exp_q.pop_front());
   // ======
   // scenarios
   initial
   begin
      void'($urandom(17754));
      resistor_settings = cpc_pkg::cpc_settings_t'($urandom());
      host_settings = cpc_pkg::cpc_settings_t'($urandom());
      repeat (10) @(negedge clk);
      rst_n = 1'b1;
      rd(8'h05);
      rd(8'h00, 8'h3C);
      chk(active_settings, resistor_settings);
      resistor_fault = 1'b1;
      repeat (3) @(negedge clk);
      chk(charger_suspended, 1'b1);
      resistor_fault = 1'b0;
      wr(8'h85);
      chk(charger_suspended, 1'b0);
      chk(active_settings, host_settings);
      wr(8'h05);
      rd(8'h85);
      wr(8'hC5);
      chk(batt_switch_on, 1'b0);
      wr(8'h85);
      battery_switch_disable_pin = 1'b1;
      rd(8'hC5);
      battery_switch_disable_pin = 1'b0;
      rd(8'h85);
      chk(batt_switch_on, 1'b1);
      ppsm_batt_switch_on = 1'b0;
      repeat (2) @(negedge clk);
      chk(batt_switch_on, 1'b0);
      ppsm_batt_switch_on = 1'b1;
      for (int m = 0; m < 13; m++)
      begin
         wr(8'h80 | 8'(m));
         chk(path_config, m == 4 ? 2'h1 : m inside {[5:7]} ? 2'h3 : m == 10 ? 2'h2 : 2'h0);
         chk(charger_enable, m inside {[5:7]});
      end
      rd(8'h80);
      wr(8'hA5);
      chk({input_standby, dcdc_on, path_config}, 4'h8);
      rd(8'hA0);
      wr(8'h85);
      repeat (40) @(negedge clk);
      chk(watchdog_expired, 1'b0);
      wr(8'h95);
      for (int n = 0; n < 3; n++)
      begin
         repeat (10) @(negedge clk);
         i_cpc_ctrl_model.kick();
      end
      chk(watchdog_expired, 1'b0);
      repeat (100) if (watchdog_expired !== 1'b1) @(negedge clk);
      chk(watchdog_expired, 1'b1);
      if (watchdog_expired !== 1'b1)
         stop_test();
      rd(8'h94);
      chk(path_config, 2'h1);
      i_cpc_ctrl_model.kick();
      repeat (2) @(negedge clk);
      chk(watchdog_expired, 1'b0);
      repeat (100) if (watchdog_expired !== 1'b1) @(negedge clk);
      chk(watchdog_expired, 1'b1);
      wr(8'h85);
      chk(watchdog_expired, 1'b0);
      // a mid-run reset must drop the sticky select
      rst_n = 1'b0;
      repeat (3) @(negedge clk);
      rst_n = 1'b1;
      rd(8'h05);
      repeat (2) @(negedge clk);
      stop_test();
   end
endmodule
